// file: common/pyro_link_pkg.sv
// Purpose: Shared constants, types and timing for the one-wire sensor readout link.
// Assumes: A single 25 MHz clock drives all link logic.
// Notes:   Times are kept in nanoseconds; cycle counts are derived from them.
package pyro_link_pkg;

  // ----------------------------------------------------------------
  // Clock and widths
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int CHAN_W        = 14;
  localparam int PKT_W         = 28;
  localparam int BIT_IDX_W     = 5;
  localparam int CNT_W         = 20;

  // One sample; first_channel lands in packet bits 27..14, temperature in 13..0.
  typedef struct packed {
    logic [CHAN_W-1:0] first_channel;
    logic [CHAN_W-1:0] temp_counts;
  } sample_t;

  // ----------------------------------------------------------------
  // Range limits and packet layout
  // ----------------------------------------------------------------
  localparam logic [CHAN_W-1:0]    RANGE_LO  = 14'h01ff;
  localparam logic [CHAN_W-1:0]    RANGE_HI  = 14'h3e01;
  localparam logic [BIT_IDX_W-1:0] LAST_BIT  = 5'h1b;
  localparam logic [BIT_IDX_W-1:0] FINAL_BIT = 5'h00;

  // ----------------------------------------------------------------
  // Times in nanoseconds
  // ----------------------------------------------------------------
  localparam int START_HIGH_DURATION_NS = 110000;
  localparam int INT_PULSE_NS           = 75000;
  localparam int TERM_LOW_NS            = 145000;
  localparam int SAMPLE_PERIOD_NS       = 14600000;
  localparam int DISCHARGE_NS           = 16000000;
  localparam int BIT_RELEASE_NS         = 200;
  localparam int BIT_HOLD_NS            = 12000;

  // Least time rounded up to whole cycles, never below one.
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time rounded down to whole cycles, never below one.
  function automatic int max_cycles(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int START_HIGH_CYC  = min_cycles(START_HIGH_DURATION_NS);
  localparam int INT_PULSE_CYC   = min_cycles(INT_PULSE_NS);
  localparam int TERM_LOW_CYC    = min_cycles(TERM_LOW_NS);
  localparam int BIT_RELEASE_CYC = min_cycles(BIT_RELEASE_NS);
  localparam int BIT_HOLD_CYC    = max_cycles(BIT_HOLD_NS);
  localparam int SAMPLE_PERIOD_CYC = max_cycles(SAMPLE_PERIOD_NS);
  localparam int DISCHARGE_CYC     = min_cycles(DISCHARGE_NS);

  // Link sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_HOST_HIGH,
    ST_INT_DRIVE,
    ST_INT_WAIT,
    ST_BIT_WAIT,
    ST_BIT_DRIVE,
    ST_TERM_WAIT
  } link_state_t;

endpackage

// file: dv/pyro_host_model.sv
// Purpose: Host model that starts, strobes and ends packets on the link wire.
// Assumes: The wire carries a weak keeper and no pull resistor.
// Notes:   Every task starts and ends just after a rising ref_clk edge.
`timescale 1ns/1ps

module pyro_host_model (
  input  wire logic ref_clk,
  input  wire logic link_out,
  input  wire logic link_oe_n,
  output logic      link_in
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  logic host_en  = 1'b0;
  logic host_val = 1'b0;
  logic keep_r   = 1'b0;

  // Two parties driving different levels show as unknown.
  always_comb begin
    if (!link_oe_n && host_en && (link_out !== host_val)) begin
      link_in = 1'bx;
    end else if (!link_oe_n) begin
      link_in = link_out;
    end else if (host_en) begin
      link_in = host_val;
    end else begin
      link_in = keep_r;
    end
  end

  // The keeper holds the last driven level once both sides let go.
  always @(posedge ref_clk) begin
    if (!link_oe_n || host_en) begin
      keep_r <= link_in;
    end
  end

  // ----------------------------------------------------------------
  // Host actions
  // ----------------------------------------------------------------
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic put(input logic en, input logic v);
    host_en  = en;
    host_val = v;
  endtask

  // Forced start: high for more than 110 us, then low.
  task automatic start_forced();
    put(1'b1, 1'b1);
    wait_cyc(2760);
    put(1'b1, 1'b0);
    wait_cyc(60);
  endtask

  // Interrupt start: stay released, then pull low once 75 us have passed.
  task automatic start_int(output int idle_cyc, output logic oe_in, output logic oe_after);
    put(1'b0, 1'b0);
    idle_cyc = 0;
    while (link_in !== 1'b1 && idle_cyc < 4000) begin
      wait_cyc(1);
      idle_cyc++;
    end
    wait_cyc(1860);
    oe_in = link_oe_n;
    wait_cyc(40);
    oe_after = link_oe_n;
    put(1'b1, 1'b0);
    wait_cyc(60);
  endtask

  // Strobe n bits, most significant first, shifting each into acc.
  task automatic read_bits(input int n, inout logic [27:0] acc);
    for (int i = 0; i < n; i++) begin
      put(1'b1, 1'b1);
      wait_cyc(5);
      put(1'b0, 1'b0);
      wait_cyc(40);
      acc = {acc[26:0], link_in};
      put(1'b1, 1'b0);
      wait_cyc(270);
    end
  endtask

  // End or cancel a packet with a low of over 145 us, then let go.
  task automatic terminate();
    put(1'b1, 1'b0);
    wait_cyc(3640);
    put(1'b0, 1'b0);
  endtask
endmodule

// file: dv/test_pyro_link_dev.sv
// Purpose: Self-checking bench for the sensor-side link sequencer.
// Assumes: Host model on the wire; idle and discharge counts are shortened.
// Notes:   Table rows cover range limits; abort, buffer and interrupt follow.
`timescale 1ns/1ps

module test_pyro_link_dev;
  localparam int SPC = 2000;
  localparam int DSC = 50;

  typedef struct packed {
    pyro_link_pkg::sample_t smp;
    logic                   disch;
  } row_t;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic                   ref_clk;
  logic                   sys_rst;
  pyro_link_pkg::sample_t smp_data;
  logic                   smp_valid;
  logic                   smp_ready;
  logic                   link_in;
  logic                   link_out;
  logic                   link_oe_n;
  logic                   discharge;
  logic                   int_mode;
  int                     fail_count = 0;
  int                     check_count = 0;
  int                     cyc_count = 0;

  row_t rows [4] = '{'{'{14'h01ff, 14'h1a2b}, 1'b0}, '{'{14'h01fe, 14'h0001}, 1'b1},
                     '{'{14'h3e01, 14'h3fff}, 1'b0}, '{'{14'h3e02, 14'h2aaa}, 1'b1}};

  pyro_link_dev #(.SAMPLE_PERIOD_CYC(SPC), .DISCHARGE_CYC(DSC)) u_pyro_link_dev (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .smp_data(smp_data), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .link_in(link_in), .link_out(link_out),
    .link_oe_n(link_oe_n), .discharge(discharge), .int_mode(int_mode)
  );

  pyro_host_model u_pyro_host_model (
    .ref_clk(ref_clk), .link_out(link_out), .link_oe_n(link_oe_n), .link_in(link_in)
  );

  // Free-running 25 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Offer one word and hold it until the buffer has taken it.
  task automatic push(input pyro_link_pkg::sample_t d);
    int n;
    n = 0;
    smp_data  = d;
    smp_valid = 1'b1;
    while (smp_ready !== 1'b1 && n < 50) begin
      step(1);
      n++;
    end
    step(1);
    smp_valid = 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge ref_clk) begin
    cyc_count++;
    if (cyc_count >= 100000) begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [27:0] acc;
    int          idle;
    logic        oe_a;
    logic        oe_b;
    smp_data  = '0;
    smp_valid = 1'b0;
    sys_rst   = 1'b1;
    step(2);
    check(28'({link_oe_n, link_out, discharge, int_mode, smp_ready}), 28'h11);
    sys_rst = 1'b0;
    step(3);
    // Ordinary forced readouts across the range limits.
    for (int i = 0; i < 4; i++) begin
      push(rows[i].smp);
      step(6);
      check(28'(discharge), 28'(rows[i].disch));
      step(64);
      check(28'(discharge), 28'h0);
      acc = '0;
      u_pyro_host_model.start_forced();
      u_pyro_host_model.read_bits(28, acc);
      check(acc, rows[i].smp);
      check(28'(int_mode), 28'h0);
      u_pyro_host_model.terminate();
    end
    // Abort after five bits while the buffer fills and refuses a third word.
    acc = '0;
    u_pyro_host_model.start_forced();
    u_pyro_host_model.read_bits(5, acc);
    check(28'(acc[4:0]), 28'(rows[3].smp[27:23]));
    push(rows[0].smp);
    step(1);
    push(rows[2].smp);
    step(1);
    smp_data  = rows[1].smp;
    smp_valid = 1'b1;
    step(1);
    check(28'(smp_ready), 28'h0);
    smp_valid = 1'b0;
    u_pyro_host_model.terminate();
    // A high shorter than the forced start time is no start, so every bit reads as one.
    u_pyro_host_model.put(1'b1, 1'b1);
    step(100);
    u_pyro_host_model.put(1'b1, 1'b0);
    step(60);
    acc = '0;
    u_pyro_host_model.read_bits(8, acc);
    check(28'(acc[7:0]), 28'hff);
    // A start with no bits read, cancelled at once.
    u_pyro_host_model.start_forced();
    check(28'(int_mode), 28'h0);
    u_pyro_host_model.terminate();
    // Device-raised start after the idle period; the last drained word is sent.
    u_pyro_host_model.start_int(idle, oe_a, oe_b);
    check(28'(idle >= 1880 && idle <= 1980), 28'h1);
    check(28'({oe_a, oe_b}), 28'h1);
    acc = '0;
    u_pyro_host_model.read_bits(28, acc);
    check(acc, rows[2].smp);
    check(28'(int_mode), 28'h1);
    u_pyro_host_model.terminate();
    step(10);
    final_report();
  end
endmodule

// file: verilog/pyro_link_dev.sv
// Purpose: Sensor-side sequencer of the one-wire readout link.
// Assumes: Samples arrive on a valid/ready stream in the ref_clk domain.
// Notes:   The link pin is split into input, output and active-low enable.
`timescale 1ns/1ps

module pyro_link_dev #(
  parameter int SAMPLE_PERIOD_CYC = pyro_link_pkg::SAMPLE_PERIOD_CYC,
  parameter int DISCHARGE_CYC     = pyro_link_pkg::DISCHARGE_CYC
) (
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire pyro_link_pkg::sample_t  smp_data,
  input  wire logic                    smp_valid,
  output logic                         smp_ready,
  input  wire logic                    link_in,
  output logic                         link_out,
  output logic                         link_oe_n,
  output logic                         discharge,
  output logic                         int_mode
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam logic [pyro_link_pkg::CNT_W-1:0] START_C =
    pyro_link_pkg::CNT_W'(pyro_link_pkg::START_HIGH_CYC);
  localparam logic [pyro_link_pkg::CNT_W-1:0] INTP_C =
    pyro_link_pkg::CNT_W'(pyro_link_pkg::INT_PULSE_CYC);
  localparam logic [pyro_link_pkg::CNT_W-1:0] TERM_C =
    pyro_link_pkg::CNT_W'(pyro_link_pkg::TERM_LOW_CYC);
  localparam logic [pyro_link_pkg::CNT_W-1:0] REL_C =
    pyro_link_pkg::CNT_W'(pyro_link_pkg::BIT_RELEASE_CYC);
  localparam logic [pyro_link_pkg::CNT_W-1:0] HOLD_C =
    pyro_link_pkg::CNT_W'(pyro_link_pkg::BIT_HOLD_CYC);
  localparam logic [pyro_link_pkg::CNT_W-1:0] SMPL_C = pyro_link_pkg::CNT_W'(SAMPLE_PERIOD_CYC);
  localparam logic [pyro_link_pkg::CNT_W-1:0] DIS_C  = pyro_link_pkg::CNT_W'(DISCHARGE_CYC);
  localparam logic [pyro_link_pkg::CNT_W-1:0] ONE_C  = 20'h00001;

  pyro_link_pkg::link_state_t        state_r;
  pyro_link_pkg::link_state_t        state_nxt;
  pyro_link_pkg::sample_t            buf_data;
  pyro_link_pkg::sample_t            cur_r;
  logic [pyro_link_pkg::PKT_W-1:0]   pkt_r;
  logic [pyro_link_pkg::BIT_IDX_W-1:0] bit_idx_r;
  logic [pyro_link_pkg::CNT_W-1:0]   tmr_r;
  logic [pyro_link_pkg::CNT_W-1:0]   low_cnt_r;
  logic [pyro_link_pkg::CNT_W-1:0]   dis_cnt_r;
  logic                              buf_valid;
  logic                              buf_ready;
  logic                              pop;
  logic                              meta_r;
  logic                              s2_r;
  logic                              s3_r;
  logic                              line_r;
  logic                              line_rise;
  logic                              line_fall;
  logic                              term_pulse;
  logic                              load_pkt;

  // Out-of-range test on the channel count.
  function automatic logic out_of_range(input logic [pyro_link_pkg::CHAN_W-1:0] v);
    return (v < pyro_link_pkg::RANGE_LO) || (v > pyro_link_pkg::RANGE_HI);
  endfunction

  // ----------------------------------------------------------------
  // Sample path
  // ----------------------------------------------------------------
  // The buffer drains only while idle, so a running packet stalls the source once two words wait.
  sample_buf2 u_buf (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_data   (smp_data),
    .in_valid  (smp_valid),
    .in_ready  (smp_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready)
  );
  assign buf_ready = (state_r == pyro_link_pkg::ST_IDLE);
  assign pop       = buf_valid && buf_ready;

  // Latest sample kept as two 14-bit unsigned counts.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_r <= '0;
    end else if (pop) begin
      cur_r <= buf_data;
    end
  end

  // Discharge timer restarts on every out-of-range sample.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dis_cnt_r <= '0;
      discharge <= 1'b0;
    end else if (pop && out_of_range(buf_data.first_channel)) begin
      dis_cnt_r <= DIS_C - ONE_C;
      discharge <= 1'b1;
    end else if (dis_cnt_r != '0) begin
      dis_cnt_r <= dis_cnt_r - ONE_C;
    end else begin
      discharge <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Line input conditioning
  // ----------------------------------------------------------------
  // Three flops; the level changes once the last two agree.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      s2_r   <= 1'b0;
      s3_r   <= 1'b0;
      line_r <= 1'b0;
    end else begin
      meta_r <= link_in;
      s2_r   <= meta_r;
      s3_r   <= s2_r;
      if (s2_r == s3_r) begin
        line_r <= s3_r;
      end
    end
  end
  assign line_rise = (s2_r == s3_r) && s3_r && !line_r;
  assign line_fall = (s2_r == s3_r) && !s3_r && line_r;

  // Continuous low time; a long low is the termination or abort pulse.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_r <= '0;
    end else if (line_r || line_rise) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != TERM_C) begin
      low_cnt_r <= low_cnt_r + ONE_C;
    end
  end
  assign term_pulse = (low_cnt_r == TERM_C - ONE_C) && !line_r && !line_rise;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state from line events and the shared timer.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pyro_link_pkg::ST_IDLE: begin
        if (line_rise) begin
          state_nxt = pyro_link_pkg::ST_HOST_HIGH;
        end else if (tmr_r == SMPL_C - ONE_C) begin
          state_nxt = pyro_link_pkg::ST_INT_DRIVE;
        end
      end
      pyro_link_pkg::ST_HOST_HIGH: begin
        if (line_fall) begin
          state_nxt = (tmr_r >= START_C) ? pyro_link_pkg::ST_BIT_WAIT
                                         : pyro_link_pkg::ST_IDLE;
        end
      end
      pyro_link_pkg::ST_INT_DRIVE: begin
        if (tmr_r == INTP_C - ONE_C) begin
          state_nxt = pyro_link_pkg::ST_INT_WAIT;
        end
      end
      pyro_link_pkg::ST_INT_WAIT: begin
        if (line_fall) begin
          state_nxt = pyro_link_pkg::ST_BIT_WAIT;
        end
      end
      pyro_link_pkg::ST_BIT_WAIT: begin
        if (line_rise) begin
          state_nxt = pyro_link_pkg::ST_BIT_DRIVE;
        end
      end
      pyro_link_pkg::ST_BIT_DRIVE: begin
        if (tmr_r == HOLD_C - ONE_C) begin
          state_nxt = (bit_idx_r == pyro_link_pkg::FINAL_BIT) ?
                      pyro_link_pkg::ST_TERM_WAIT : pyro_link_pkg::ST_BIT_WAIT;
        end
      end
      pyro_link_pkg::ST_TERM_WAIT: begin
        state_nxt = state_r;
      end
      default: begin
        state_nxt = pyro_link_pkg::ST_IDLE;
      end
    endcase
    if (term_pulse && state_r != pyro_link_pkg::ST_IDLE) begin
      state_nxt = pyro_link_pkg::ST_IDLE;
    end
  end

  // State register.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= pyro_link_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Shared timer restarts on every state change.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_r <= '0;
    end else if (state_nxt != state_r) begin
      tmr_r <= '0;
    end else if (tmr_r != {pyro_link_pkg::CNT_W{1'b1}}) begin
      tmr_r <= tmr_r + ONE_C;
    end
  end

  // Packet is frozen at the start condition and walked from bit 27 down.
  assign load_pkt = (state_r == pyro_link_pkg::ST_IDLE) && (state_nxt != state_r);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pkt_r     <= '0;
      bit_idx_r <= pyro_link_pkg::LAST_BIT;
    end else if (load_pkt) begin
      pkt_r     <= cur_r;
      bit_idx_r <= pyro_link_pkg::LAST_BIT;
    end else if (state_r == pyro_link_pkg::ST_BIT_DRIVE &&
                 state_nxt == pyro_link_pkg::ST_BIT_WAIT) begin
      bit_idx_r <= bit_idx_r - 5'h01;
    end
  end

  // Interrupt mode flag for the current transaction.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_mode <= 1'b0;
    end else if (state_r == pyro_link_pkg::ST_INT_DRIVE) begin
      int_mode <= 1'b1;
    end else if (state_r == pyro_link_pkg::ST_HOST_HIGH) begin
      int_mode <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // High during the interrupt pulse; low for a zero bit after a short release gap.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      link_out  <= 1'b0;
      link_oe_n <= 1'b1;
    end else if (state_nxt == pyro_link_pkg::ST_INT_DRIVE) begin
      link_out  <= 1'b1;
      link_oe_n <= 1'b0;
    end else if (state_nxt == pyro_link_pkg::ST_BIT_DRIVE && state_r == state_nxt &&
                 tmr_r >= REL_C - ONE_C && !pkt_r[bit_idx_r]) begin
      link_out  <= 1'b0;
      link_oe_n <= 1'b0;
    end else begin
      link_out  <= 1'b0;
      link_oe_n <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_drive_only_active: assert property (!link_oe_n |-> $past(state_nxt) inside
      {pyro_link_pkg::ST_INT_DRIVE, pyro_link_pkg::ST_BIT_DRIVE})
    else $error("link driven outside drive states");
  a_one_never_low: assert property (state_r == pyro_link_pkg::ST_BIT_DRIVE &&
      pkt_r[bit_idx_r] |-> link_oe_n)
    else $error("one bit was pulled low");
  a_zero_pulled_low: assert property (state_r == pyro_link_pkg::ST_BIT_DRIVE &&
      tmr_r == REL_C && !pkt_r[bit_idx_r] |-> !link_oe_n && !link_out)
    else $error("zero bit not pulled low");
  a_int_timeout: assert property (state_r == pyro_link_pkg::ST_IDLE && !line_rise &&
      !term_pulse && tmr_r == SMPL_C - ONE_C |=> !link_oe_n && link_out)
    else $error("interrupt not raised after idle timeout");
  a_int_pulse_len: assert property ($rose(state_r == pyro_link_pkg::ST_INT_DRIVE) |->
      (state_r == pyro_link_pkg::ST_INT_DRIVE)[*8])
    else $error("interrupt pulse too short");
  a_term_to_idle: assert property (term_pulse && state_r != pyro_link_pkg::ST_IDLE |=>
      state_r == pyro_link_pkg::ST_IDLE && link_oe_n)
    else $error("termination pulse ignored");
  a_short_force: assert property (state_r == pyro_link_pkg::ST_HOST_HIGH && line_fall &&
      tmr_r < START_C && !term_pulse |=> state_r == pyro_link_pkg::ST_IDLE)
    else $error("short high accepted as start");
  a_range_discharge: assert property (pop && out_of_range(buf_data.first_channel) |=>
      discharge [*8])
    else $error("out of range sample did not discharge");
  a_pkt_frozen: assert property (state_r == pyro_link_pkg::ST_BIT_WAIT && !term_pulse |=>
      $stable(pkt_r) && !pop)
    else $error("packet changed mid transfer");

  c_forced_start: cover property (state_r == pyro_link_pkg::ST_HOST_HIGH &&
      state_nxt == pyro_link_pkg::ST_BIT_WAIT);
  c_int_start: cover property (state_r == pyro_link_pkg::ST_INT_WAIT && line_fall);
  c_full_packet: cover property (state_r == pyro_link_pkg::ST_TERM_WAIT && term_pulse);
  c_abort: cover property (state_r == pyro_link_pkg::ST_BIT_WAIT && term_pulse);

endmodule

// file: verilog/sample_buf2.sv
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Same clock on both sides.
// Notes:   Full drops in_ready; a stalled drain therefore reaches the source.
`timescale 1ns/1ps

module sample_buf2 (
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire pyro_link_pkg::sample_t  in_data,
  input  wire logic                    in_valid,
  output logic                         in_ready,
  output pyro_link_pkg::sample_t       out_data,
  output logic                         out_valid,
  input  wire logic                    out_ready
);

  pyro_link_pkg::sample_t mem_r [2];
  logic                   wr_ptr_r;
  logic                   rd_ptr_r;
  logic [1:0]             count_r;
  logic                   push;
  logic                   pop;

  // Handshake terms come straight from the fill level.
  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage and write pointer.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= 1'b0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else if (push) begin
      mem_r[wr_ptr_r] <= in_data;
      wr_ptr_r        <= ~wr_ptr_r;
    end
  end

  // Read pointer and fill level.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end else begin
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push && !pop) begin
        count_r <= count_r + 2'h1;
      end else if (pop && !push) begin
        count_r <= count_r - 2'h1;
      end
    end
  end

endmodule
